// >>> verilog/operating_mode_control.sv
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "opmode_defines.svh"

module operating_mode_control #(
    parameter int HIGH_LOG2 = 19,
    parameter int LOW_LOG2 = 13,
    parameter logic [15:0] LOW_DIV = 16'h0EE7
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic release_pin,
    input wire logic irq_wake,
    input wire logic irq_master_flag,
    output logic cpu_run,
    output logic watchdog_run,
    output logic periph_run,
    output logic high_osc_enable,
    output logic low_osc_enable,
    output logic main_clock_low,
    output logic port_float,
    output logic reset_out_b,
    output logic [1:0] run_mode,
    output logic [20:0] timing_divider,
    output logic idle_wake_resume,
    output logic idle_wake_service
);

    opmode_pkg::state_t s_q;
    opmode_pkg::state_t s_d;
    logic rise;
    logic low_tick;
    logic div_tick;
    logic [7:0] wdat;

    // Three-fold or single power-of-two count, minus one for a zero-based compare
    function automatic logic [20:0] warm_last(input logic [1:0] sel, input logic slow);
        logic [20:0] base;
        base = slow ? (21'h00_0001 << LOW_LOG2) : (21'h00_0001 << HIGH_LOG2);
        if (sel == `WARM_SEL_LONG) begin
            warm_last = base + (base << 1) - 21'h00_0001;
        end else begin
            warm_last = base - 21'h00_0001;
        end
    endfunction : warm_last

    function automatic opmode_pkg::ret_mode_t ret_of(input logic hi, input logic lo,
                                                      input logic sel);
        if (sel) begin
            ret_of = opmode_pkg::RET_SLOW;
        end else if (hi && lo) begin
            ret_of = opmode_pkg::RET_DUAL;
        end else begin
            ret_of = opmode_pkg::RET_SINGLE;
        end
    endfunction : ret_of

    always_comb begin
        s_d = s_q;
        wdat = wb_dat_i[7:0];
        s_d.ack = 1'b0;
        s_d.wake_irq = 1'b0;
        s_d.wake_svc = 1'b0;
        s_d.pin_q = release_pin;
        rise = release_pin && !s_q.pin_q;
        // Edge style stays in force until a rising edge arms level style
        if (!s_q.style_sel) begin
            s_d.eff_level = 1'b0;
        end else if (rise) begin
            s_d.eff_level = 1'b1;
        end
        // Slow-clock enable; held at zero in halt since the oscillator is off
        low_tick = 1'b0;
        if (s_q.mode == opmode_pkg::MODE_HALT) begin
            s_d.low_cnt = 16'h0000;
        end else if (s_q.low_cnt == LOW_DIV - 16'h0001) begin
            s_d.low_cnt = 16'h0000;
            low_tick = 1'b1;
        end else begin
            s_d.low_cnt = s_q.low_cnt + 16'h0001;
        end
        if (s_q.mode == opmode_pkg::MODE_WARM) begin
            div_tick = (s_q.ret == opmode_pkg::RET_SLOW) ? low_tick : 1'b1;
        end else begin
            div_tick = s_q.main_clock_select ? low_tick : 1'b1;
        end

        // Bus slave: one wait state, unmapped reads return zero
        if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
            s_d.ack = 1'b1;
            unique case (wb_adr_i)
                `OFS_SYS_CTRL_ONE: begin
                    s_d.dat = 8'h00;
                    s_d.dat[`SC1_HALT_BIT] = s_q.halt_req;
                    s_d.dat[`SC1_STYLE_BIT] = s_q.style_sel;
                    s_d.dat[`SC1_DRIVE_BIT] = s_q.port_drive;
                    s_d.dat[`SC1_WARM_HI:`SC1_WARM_LO] = s_q.warm_sel;
                end
                `OFS_SYS_CTRL_TWO: begin
                    s_d.dat = `SC2_ONES_MASK;
                    s_d.dat[`SC2_HIGH_OSC_BIT] = s_q.high_osc_on;
                    s_d.dat[`SC2_LOW_OSC_BIT] = s_q.low_osc_on;
                    s_d.dat[`SC2_CLK_SEL_BIT] = s_q.main_clock_select;
                    s_d.dat[`SC2_IDLE_BIT] = s_q.idle;
                end
                `OFS_MODE_STATUS: begin
                    s_d.dat = {3'h0, s_q.eff_level, s_q.ret, s_q.mode};
                end
                default: begin
                    s_d.dat = 8'h00;
                end
            endcase
            if (wb_we_i && wb_sel_i[0] && s_q.mode == opmode_pkg::MODE_RUN) begin
                if (wb_adr_i == `OFS_SYS_CTRL_ONE) begin
                    s_d.halt_req = wdat[`SC1_HALT_BIT];
                    s_d.style_sel = wdat[`SC1_STYLE_BIT];
                    s_d.port_drive = wdat[`SC1_DRIVE_BIT];
                    s_d.warm_sel = wdat[`SC1_WARM_HI:`SC1_WARM_LO];
                end else if (wb_adr_i == `OFS_SYS_CTRL_TWO) begin
                    s_d.high_osc_on = wdat[`SC2_HIGH_OSC_BIT];
                    s_d.low_osc_on = wdat[`SC2_LOW_OSC_BIT];
                    s_d.main_clock_select = wdat[`SC2_CLK_SEL_BIT];
                    s_d.idle = wdat[`SC2_IDLE_BIT];
                end
            end
        end

        unique case (s_q.mode)
            opmode_pkg::MODE_RUN: begin
                s_d.div = s_q.div + {20'h0_0000, div_tick};
                if (s_q.halt_req) begin
                    s_d.ret = ret_of(s_q.high_osc_on, s_q.low_osc_on, s_q.main_clock_select);
                    s_d.div = 21'h00_0000;
                    if (s_q.eff_level && release_pin) begin
                        s_d.mode = opmode_pkg::MODE_WARM;
                    end else begin
                        s_d.mode = opmode_pkg::MODE_HALT;
                    end
                end else if (s_q.idle) begin
                    s_d.mode = opmode_pkg::MODE_DOZE;
                end
            end
            opmode_pkg::MODE_HALT: begin
                s_d.div = 21'h00_0000;
                if (s_q.eff_level ? release_pin : rise) begin
                    s_d.mode = opmode_pkg::MODE_WARM;
                end
            end
            opmode_pkg::MODE_WARM: begin
                if (s_q.div == warm_last(s_q.warm_sel, s_q.ret == opmode_pkg::RET_SLOW)) begin
                    s_d.div = 21'h00_0000;
                    s_d.halt_req = 1'b0;
                    s_d.mode = opmode_pkg::MODE_RUN;
                end else begin
                    s_d.div = s_q.div + {20'h0_0000, div_tick};
                end
            end
            opmode_pkg::MODE_DOZE: begin
                s_d.div = s_q.div + {20'h0_0000, div_tick};
                if (irq_wake) begin
                    s_d.idle = 1'b0;
                    s_d.mode = opmode_pkg::MODE_RUN;
                    s_d.wake_svc = irq_master_flag;
                    s_d.wake_irq = !irq_master_flag;
                end
            end
        endcase

        // Both oscillators off would leave no clock: reload and pulse reset out
        if (s_q.rst_cnt != 4'h0) begin
            s_d.rst_cnt = s_q.rst_cnt - 4'h1;
        end
        if (!s_d.high_osc_on && !s_d.low_osc_on) begin
            s_d.rst_cnt = `SOFT_RESET_HOLD;
            s_d.mode = opmode_pkg::MODE_RUN;
            s_d.ret = opmode_pkg::RET_DUAL;
            s_d.halt_req = 1'b0;
            s_d.style_sel = 1'b0;
            s_d.eff_level = 1'b0;
            s_d.port_drive = 1'b0;
            s_d.warm_sel = 2'h0;
            s_d.high_osc_on = 1'b1;
            s_d.low_osc_on = 1'b1;
            s_d.main_clock_select = 1'b0;
            s_d.idle = 1'b0;
            s_d.div = 21'h00_0000;
        end
    end

    // Reset pin is the async reset, so it ends halt at once external_irq_zero dual-clock run
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{mode: opmode_pkg::MODE_RUN, ret: opmode_pkg::RET_DUAL,
                     halt_req: 1'b0, style_sel: 1'b0, port_drive: 1'b0, warm_sel: 2'h0,
                     high_osc_on: 1'b1, low_osc_on: 1'b1, main_clock_select: 1'b0,
                     idle: 1'b0, eff_level: 1'b0, pin_q: 1'b0, div: 21'h00_0000,
                     low_cnt: 16'h0000, ack: 1'b0, dat: 8'h00, rst_cnt: 4'h0,
                     wake_irq: 1'b0, wake_svc: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = {24'h00_0000, s_q.dat};
    assign cpu_run = s_q.mode == opmode_pkg::MODE_RUN && s_q.rst_cnt == 4'h0;
    assign watchdog_run = s_q.mode == opmode_pkg::MODE_RUN;
    assign periph_run = s_q.mode == opmode_pkg::MODE_RUN || s_q.mode == opmode_pkg::MODE_DOZE;
    // Warm-up oscillators follow the mode that halt will return to
    assign high_osc_enable = (s_q.mode == opmode_pkg::MODE_HALT) ? 1'b0 :
        (s_q.mode == opmode_pkg::MODE_WARM) ? (s_q.ret != opmode_pkg::RET_SLOW) :
        s_q.high_osc_on;
    assign low_osc_enable = (s_q.mode == opmode_pkg::MODE_HALT) ? 1'b0 :
        (s_q.mode == opmode_pkg::MODE_WARM) ? (s_q.ret != opmode_pkg::RET_SINGLE) :
        s_q.low_osc_on;
    assign main_clock_low = s_q.main_clock_select;
    assign port_float = (s_q.mode == opmode_pkg::MODE_HALT ||
                         s_q.mode == opmode_pkg::MODE_WARM) && !s_q.port_drive;
    assign reset_out_b = s_q.rst_cnt == 4'h0;
    assign run_mode = ret_of(s_q.high_osc_on, s_q.low_osc_on, s_q.main_clock_select);
    assign timing_divider = s_q.div;
    assign idle_wake_resume = s_q.wake_irq;
    assign idle_wake_service = s_q.wake_svc;

endmodule : operating_mode_control
`default_nettype wire

// >>> verilog/opmode_defines.svh
`ifndef OPMODE_DEFINES_SVH
`define OPMODE_DEFINES_SVH

// Register byte offsets
`define OFS_SYS_CTRL_ONE 8'h00
`define OFS_SYS_CTRL_TWO 8'h04
`define OFS_MODE_STATUS 8'h08

// First system control register fields
`define SC1_HALT_BIT 7
`define SC1_STYLE_BIT 6
`define SC1_DRIVE_BIT 4
`define SC1_WARM_HI 3
`define SC1_WARM_LO 2
`define SC1_RESET 8'h00

// Second system control register fields
`define SC2_HIGH_OSC_BIT 7
`define SC2_LOW_OSC_BIT 6
`define SC2_CLK_SEL_BIT 5
`define SC2_IDLE_BIT 4
`define SC2_ONES_MASK 8'h0F
`define SC2_RESET 8'hC0

// Warm-up select value for the long (three-fold) duration
`define WARM_SEL_LONG 2'h0

// Reset output hold after both oscillators are disabled, in cycles
`define SOFT_RESET_HOLD 4'h4

`endif

// >>> verilog/opmode_pkg.sv
package opmode_pkg;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_HALT,
        MODE_WARM,
        MODE_DOZE
    } mode_t;

    typedef enum logic [1:0] {
        RET_SINGLE,
        RET_DUAL,
        RET_SLOW
    } ret_mode_t;

    typedef struct packed {
        mode_t mode;
        ret_mode_t ret;
        logic halt_req;
        logic style_sel;
        logic port_drive;
        logic [1:0] warm_sel;
        logic high_osc_on;
        logic low_osc_on;
        logic main_clock_select;
        logic idle;
        logic eff_level;
        logic pin_q;
        logic [20:0] div;
        logic [15:0] low_cnt;
        logic ack;
        logic [7:0] dat;
        logic [3:0] rst_cnt;
        logic wake_irq;
        logic wake_svc;
    } state_t;

endpackage : opmode_pkg

// >>> test/opmode_sva.sv
`timescale 1ns/100ps
`default_nettype none
module opmode_sva (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic cpu_run,
    input wire logic watchdog_run,
    input wire logic periph_run,
    input wire logic port_float,
    input wire logic reset_out_b,
    input wire logic [20:0] timing_divider,
    input wire logic idle_wake_resume,
    input wire logic idle_wake_service
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    doze_stop_a: assert property (periph_run && !watchdog_run |-> !cpu_run)
        else $error("cpu runs while watchdog stopped");
    halt_div_a: assert property ($fell(periph_run) |-> timing_divider == 21'h0)
        else $error("divider not cleared on halt entry");
    resume_div_a: assert property ($rose(periph_run) |-> timing_divider == 21'h0)
        else $error("divider not cleared on resume");
    port_float_a: assert property (port_float |-> !periph_run)
        else $error("ports float while running");
    soft_rst_a: assert property ($fell(reset_out_b) |-> !reset_out_b [*4] ##1 reset_out_b)
        else $error("reset output pulse length wrong");
    wake_run_a: assert property (idle_wake_resume || idle_wake_service |->
        cpu_run && !(idle_wake_resume && idle_wake_service))
        else $error("idle wake pulse without run");
endmodule : opmode_sva

bind operating_mode_control opmode_sva chk (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .cpu_run, .watchdog_run, .periph_run, .port_float, .reset_out_b, .timing_divider,
    .idle_wake_resume, .idle_wake_service);
`default_nettype wire

// >>> test/release_driver.sv
`timescale 1ns/100ps
`default_nettype none
module release_driver (
    input wire logic ref_clk,
    input wire logic pin_lvl,
    output var logic release_pin
);
    // Not reset: the outside driver keeps its level through a device reset
    always_ff @(posedge ref_clk) begin
        release_pin <= pin_lvl;
    end
endmodule : release_driver
`default_nettype wire

// >>> test/operating_mode_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module operating_mode_control_test;
    logic ref_clk, rst_b, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, release_pin, irq_wake;
    logic irq_master_flag, cpu_run, watchdog_run, periph_run, high_osc_enable, low_osc_enable;
    logic main_clock_low, port_float, reset_out_b, idle_wake_resume, idle_wake_service, pin_lvl;
    logic [7:0] wb_adr_i, rd;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0] wb_sel_i;
    logic [1:0] run_mode;
    logic [20:0] timing_divider;
    int fails, checks, n, k;

    operating_mode_control #(.HIGH_LOG2(4), .LOW_LOG2(3), .LOW_DIV(16'h0003)) DUT (.ref_clk,
        .rst_b, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
        .wb_ack_o, .release_pin, .irq_wake, .irq_master_flag, .cpu_run, .watchdog_run,
        .periph_run, .high_osc_enable, .low_osc_enable, .main_clock_low, .port_float,
        .reset_out_b, .run_mode, .timing_divider, .idle_wake_resume, .idle_wake_service);
    release_driver drv (.ref_clk, .pin_lvl, .release_pin);

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        for (k = 0; k < 50; k++) begin
            @(posedge ref_clk);
            if (wb_ack_o === 1'b1) break;
        end
        if (k == 50) begin
            fails++;
            print_verdict;
        end
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus

    // Gives the halt request time to land before counting the way back
    task wait_run(output int cnt);
        repeat (3) @(posedge ref_clk);
        for (cnt = 0; cnt < 400; cnt++) begin
            @(posedge ref_clk);
            if (cpu_run === 1'b1) break;
        end
    endtask : wait_run

    task pin(input logic v);
        @(posedge ref_clk);
        pin_lvl <= v;
    endtask : pin

    initial begin
        {rst_b, wb_we_i, wb_cyc_i, wb_stb_i, irq_wake, irq_master_flag, pin_lvl} = 7'h00;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'h1;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        bus(0, 8'h04, 8'h00);
        check(rd, 8'hCF);
        bus(0, 8'h20, 8'h00);
        check(rd, 8'h00);
        bus(1, 8'h04, 8'hE0);
        bus(0, 8'h04, 8'h00);
        check({rd, main_clock_low}, 9'h1DF);
        bus(1, 8'h04, 8'hC0);
        $display("register test done");
        pin(1);
        bus(1, 8'h00, 8'h84);
        repeat (4) @(posedge ref_clk);
        check({cpu_run, periph_run, port_float, high_osc_enable, low_osc_enable}, 5'h04);
        pin(0);
        pin(1);
        wait_run(n);
        check(n >= 12 && n <= 24, 1);
        bus(0, 8'h00, 8'h00);
        check(rd, 8'h04);
        $display("edge halt test done");
        bus(1, 8'h00, 8'h40);
        bus(1, 8'h00, 8'hC0);
        repeat (60) @(posedge ref_clk);
        check(cpu_run, 0);
        pin(0);
        pin(1);
        wait_run(n);
        check(n >= 44 && n <= 56, 1);
        bus(1, 8'h00, 8'hC0);
        wait_run(n);
        check(n >= 40 && n <= 56, 1);
        pin(0);
        bus(1, 8'h00, 8'hC0);
        repeat (60) @(posedge ref_clk);
        check(cpu_run, 0);
        pin(1);
        wait_run(n);
        check(n >= 44 && n <= 60, 1);
        bus(1, 8'h00, 8'h80);
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b0;
        @(posedge ref_clk);
        rst_b <= 1'b1;
        bus(0, 8'h00, 8'h00);
        check({rd, cpu_run, run_mode}, 11'h005);
        $display("level and reset test done");
        for (n = 0; n < 2; n++) begin
            irq_master_flag <= n[0];
            bus(1, 8'h04, 8'hD0);
            repeat (4) @(posedge ref_clk);
            check({cpu_run, watchdog_run, periph_run}, 3'h1);
            irq_wake <= 1'b1;
            for (k = 0; k < 20 && !(idle_wake_resume === 1'b1 || idle_wake_service === 1'b1); k++)
                @(posedge ref_clk);
            check({idle_wake_service, idle_wake_resume}, n + 1);
            irq_wake <= 1'b0;
            check(run_mode, 2'h1);
        end
        $display("idle test done");
        bus(1, 8'h04, 8'h00);
        for (k = 0; k < 10 && reset_out_b !== 1'b0; k++) @(posedge ref_clk);
        check(reset_out_b, 0);
        repeat (8) @(posedge ref_clk);
        bus(0, 8'h04, 8'h00);
        check(rd, 8'hCF);
        $display("soft reset test done");
        print_verdict;
    end
endmodule : operating_mode_control_test
`default_nettype wire
